// File: hw/stepper_map.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by the stepper drive package and design files only.
`ifndef STEPPER_MAP_SVH
`define STEPPER_MAP_SVH
`define SD_DW            16
`define SD_AW            5
`define SD_A_CTRL        5'h00
`define SD_A_SPEED       5'h01
`define SD_A_DRIVE       5'h02
`define SD_A_DSLOPE      5'h03
`define SD_A_DOFFS       5'h04
`define SD_A_PSLOPE      5'h05
`define SD_A_DMIN        5'h06
`define SD_A_DMAX        5'h07
`define SD_A_RUNTHR      5'h08
`define SD_A_STOPTHR     5'h09
`define SD_A_DAC         5'h0a
`define SD_A_STATUS      5'h0b
`define SD_A_IRQSTAT     5'h0c
`define SD_A_IRQMASK     5'h0d
`define SD_LUT_BIT       4
`define SD_F_MODE        0
`define SD_F_GRAN        2
`define SD_F_DIR         4
`define SD_F_LOOP        5
`define SD_F_SRC         6
`define SD_IRQ_STEP      0
`define SD_IRQ_TRIP      1
`define SD_IRQ_START     2
`define SD_IRQ_STOP      3
`define SD_RST_DSLOPE    8'h80
`define SD_RST_PSLOPE    16'h1000
`define SD_RST_DMAX      8'hff
`define SD_RST_RUNTHR    8'h08
`define SD_RST_STOPTHR   8'h05
`define SD_RST_DAC       5'h01
`define SD_STEP_UNIT     7'h10
`define SD_CLK_HZ        200000000
`define SD_OSC_HZ        32000000
`define SD_SYS_DIV       4
`define SD_PRESCALE      8
`define SD_TICK_CYC      (`SD_CLK_HZ / (`SD_OSC_HZ / `SD_SYS_DIV / `SD_PRESCALE))
`endif

// File: hw/stepper_pkg.sv
// Types shared by the stepper drive control.
// Assumes the map header for all numeric constants.
package stepper_pkg;
    // Commutation pattern, as coded in the control register.
    typedef enum logic [1:0] {
        MODE_WAVE  = 2'h0,
        MODE_FULL  = 2'h1,
        MODE_HALF  = 2'h2,
        MODE_MICRO = 2'h3
    } step_mode_e;
    // Run/stop state of the commutation engine.
    typedef enum logic [1:0] {
        ST_STOP = 2'b01,
        ST_RUN  = 2'b10
    } run_state_e;
endpackage : stepper_pkg

// File: hw/stepper_drive.sv
// Unipolar stepper drive control: speed to duty and period, sequencing, chopping.
// Assumes synchronous inputs on mclk_i and a master that never waits.
// Function
// (RQ1) Speed request is unsigned 8 bits, 0..255.
// (RQ2) Duty equals slope times speed plus offset.
// (RQ3) Period equals scaling constant over speed.
// (RQ4) Closed loop drives duty and rate together.
// (RQ5) Wave, full, half and microstep patterns.
// (RQ6) Microstep 1:4, 1:8, 1:16 from table.
// (RQ7) Direction reverses sequence; loop mode selectable.
// (RQ8) Duty clamped between minimum and maximum.
// (RQ9) Separate run and stop thresholds form hysteresis.
// (RQ10) Start above run, stop below stop.
// (RQ11) Switches advance rotor one step position.
// (RQ12) Four switch outputs, each own PWM.
// (RQ13) Comparator trip blanks PWM, auto restart.
// (RQ14) Chop threshold from 5-bit reference level.
// (RQ15) Speed from host value or potentiometer.
// (RQ16) Timer ticks at oscillator/4, prescaled by 8.
// (RQ17) Zero speed holds present step position.
`timescale 1ns/1ps
`include "stepper_map.svh"
module stepper_drive (
    input  wire logic              mclk_i,      // System clock.
    input  wire logic              reset_n_i,   // Asynchronous reset, active low.
    input  wire logic [`SD_AW-1:0] addr_i,      // Register address.
    input  wire logic [`SD_DW-1:0] wdata_i,     // Register write data.
    input  wire logic              wr_i,        // Write strobe.
    input  wire logic              rd_i,        // Read strobe.
    output logic      [`SD_DW-1:0] rdata_o,     // Read data, one cycle after the strobe.
    input  wire logic [7:0]        pot_level_i, // Digitised potentiometer reading.
    input  wire logic              chop_trip_i, // Current comparator output, high on trip.
    output logic      [4:0]        dac_level_o, // Chop reference level, 1/32 steps.
    output logic      [3:0]        sw_o,        // Winding-end switches W, X, Y, Z.
    output logic                   irq_o        // Level interrupt.
);
    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [`SD_DW-1:0] ctrl;          // Mode, granularity, direction, loop, source.
    logic [7:0]        speed_host;    // Host-written speed request.
    logic [7:0]        drive_host;    // Open-loop drive level.
    logic [7:0]        duty_slope;    // Duty slope, 0.8 fixed point.
    logic [7:0]        duty_offs;     // Minimum duty offset.
    logic [15:0]       period_slope_constant; // Period scaling constant.
    logic [7:0]        duty_min;      // Lower duty clamp.
    logic [7:0]        duty_max;      // Upper duty clamp.
    logic [7:0]        run_thr;       // Start threshold.
    logic [7:0]        stop_thr;      // Stop threshold.
    logic [3:0]        irq_stat;      // Sticky event bits.
    logic [3:0]        irq_mask;      // Interrupt enables.
    logic [7:0]        lut [16];      // Microstep drive levels.
    logic [3:0]        events;        // Event pulses of this cycle.
    logic              wr_sel;        // Write to the control bank.
    // Core state, declared here for the status read.
    stepper_pkg::run_state_e run_state; // Run/stop state.
    logic [5:0]        pos;           // Electrical position, 16 units per step.
    logic [7:0]        duty;          // Clamped duty in force.
    logic              chopped;       // PWM blanked by a trip.
    assign wr_sel = wr_i && !addr_i[`SD_LUT_BIT];

    // Control registers written by software.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl                  <= 16'h0000;
            speed_host            <= 8'h00;
            drive_host            <= 8'h00;
            duty_slope            <= `SD_RST_DSLOPE;
            duty_offs             <= 8'h00;
            period_slope_constant <= `SD_RST_PSLOPE;
            duty_min              <= 8'h00;
            duty_max              <= `SD_RST_DMAX;
            run_thr               <= `SD_RST_RUNTHR;
            stop_thr              <= `SD_RST_STOPTHR;
            dac_level_o           <= `SD_RST_DAC;
            irq_mask              <= 4'h0;
        end else if (wr_sel) begin
            unique case (addr_i)
                `SD_A_CTRL:    ctrl                  <= wdata_i;
                `SD_A_SPEED:   speed_host            <= wdata_i[7:0];
                `SD_A_DRIVE:   drive_host            <= wdata_i[7:0];
                `SD_A_DSLOPE:  duty_slope            <= wdata_i[7:0];
                `SD_A_DOFFS:   duty_offs             <= wdata_i[7:0];
                `SD_A_PSLOPE:  period_slope_constant <= wdata_i;
                `SD_A_DMIN:    duty_min              <= wdata_i[7:0];
                `SD_A_DMAX:    duty_max              <= wdata_i[7:0];
                `SD_A_RUNTHR:  run_thr               <= wdata_i[7:0];
                `SD_A_STOPTHR: stop_thr              <= wdata_i[7:0];
                `SD_A_DAC:     dac_level_o           <= wdata_i[4:0]; // RQ14
                `SD_A_IRQMASK: irq_mask              <= wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // Microstep table, loaded through the upper address window.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 16; i++) begin
                lut[i] <= 8'h00;
            end
        end else if (wr_i && addr_i[`SD_LUT_BIT]) begin
            lut[addr_i[3:0]] <= wdata_i[7:0]; // RQ6
        end
    end

    // Sticky status: a new event wins over a write-one-to-clear.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat <= 4'h0;
        end else begin
            irq_stat <= (irq_stat & ~((wr_sel && addr_i == `SD_A_IRQSTAT) ? wdata_i[3:0] : 4'h0)) | events;
        end
    end
    assign irq_o = |(irq_stat & irq_mask);

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 16'h0000;
        end else if (!rd_i) begin
            rdata_o <= 16'h0000;
        end else if (addr_i[`SD_LUT_BIT]) begin
            rdata_o <= {8'h00, lut[addr_i[3:0]]};
        end else begin
            unique case (addr_i)
                `SD_A_CTRL:    rdata_o <= ctrl;
                `SD_A_SPEED:   rdata_o <= {8'h00, speed_host};
                `SD_A_DRIVE:   rdata_o <= {8'h00, drive_host};
                `SD_A_DSLOPE:  rdata_o <= {8'h00, duty_slope};
                `SD_A_DOFFS:   rdata_o <= {8'h00, duty_offs};
                `SD_A_PSLOPE:  rdata_o <= period_slope_constant;
                `SD_A_DMIN:    rdata_o <= {8'h00, duty_min};
                `SD_A_DMAX:    rdata_o <= {8'h00, duty_max};
                `SD_A_RUNTHR:  rdata_o <= {8'h00, run_thr};
                `SD_A_STOPTHR: rdata_o <= {8'h00, stop_thr};
                `SD_A_DAC:     rdata_o <= {11'h000, dac_level_o};
                `SD_A_STATUS:  rdata_o <= {duty, pos, chopped, run_state == stepper_pkg::ST_RUN};
                `SD_A_IRQSTAT: rdata_o <= {12'h000, irq_stat};
                `SD_A_IRQMASK: rdata_o <= {12'h000, irq_mask};
                default:       rdata_o <= 16'h0000;
            endcase
        end
    end

    // ****************************************************************
    // Speed to duty and period
    // ****************************************************************
    stepper_pkg::step_mode_e mode; // Selected pattern.
    logic [7:0]  speed_req;        // Speed request in force.
    logic [15:0] slope_prod;       // Slope times speed.
    logic [8:0]  duty_raw;         // Linear duty before clamping.
    logic [8:0]  duty_src;         // Duty before clamping, per loop mode.
    logic [7:0]  next_duty;        // Clamped duty.
    logic [15:0] period;           // Timer counts per commutation.
    assign mode       = stepper_pkg::step_mode_e'(ctrl[`SD_F_MODE +: 2]);
    assign speed_req  = ctrl[`SD_F_SRC] ? pot_level_i : speed_host; // RQ15 RQ1
    assign slope_prod = duty_slope * speed_req;
    assign duty_raw   = {1'b0, slope_prod[15:8]} + {1'b0, duty_offs}; // RQ2
    // Closed loop follows the speed; open loop takes the host drive level.
    assign duty_src   = ctrl[`SD_F_LOOP] ? duty_raw : {1'b0, drive_host}; // RQ4 RQ7
    // Zero speed is never divided; it holds position instead.
    assign period     = (speed_req == 8'h00) ? 16'hffff : period_slope_constant / {8'h00, speed_req}; // RQ3

    // Clamp to the configured limits.
    always_comb begin
        if (duty_src > {1'b0, duty_max}) begin
            next_duty = duty_max; // RQ8
        end else if (duty_src < {1'b0, duty_min}) begin
            next_duty = duty_min; // RQ8
        end else begin
            next_duty = duty_src[7:0];
        end
    end

    // Duty register.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            duty <= 8'h00;
        end else begin
            duty <= next_duty;
        end
    end

    // ****************************************************************
    // Run/stop hysteresis
    // ****************************************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_state <= stepper_pkg::ST_STOP;
        end else begin
            unique case (run_state)
                stepper_pkg::ST_STOP: if (duty > run_thr) run_state <= stepper_pkg::ST_RUN;   // RQ9 RQ10
                stepper_pkg::ST_RUN:  if (duty < stop_thr) run_state <= stepper_pkg::ST_STOP; // RQ9 RQ10
                default:              run_state <= stepper_pkg::ST_STOP;
            endcase
        end
    end

    // ****************************************************************
    // Commutation timer
    // ****************************************************************
    logic [7:0]  tick_cnt;  // Prescaler to the timer rate.
    logic        tick;      // One pulse per timer count.
    logic [15:0] step_cnt;  // Timer counts in this commutation.
    logic        step_adv;  // Advance pulse.
    logic [6:0]  inc;       // Position increment per advance.
    assign tick     = (tick_cnt == 8'(`SD_TICK_CYC - 1));
    assign step_adv = tick && (step_cnt >= period) && (run_state == stepper_pkg::ST_RUN)
                      && (speed_req != 8'h00); // RQ10 RQ17

    // Prescaler from the system clock to the timer count rate.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt <= 8'h00;
        end else begin
            tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01; // RQ16
        end
    end

    // Counts timer ticks; restarts on every advance.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_cnt <= 16'h0000;
        end else if (step_adv) begin
            step_cnt <= 16'h0001;
        end else if (tick && step_cnt != 16'hffff) begin
            step_cnt <= step_cnt + 16'h0001;
        end
    end

    // Full, wave and half use whole or half steps; micro uses the granularity.
    always_comb begin
        unique case (mode)
            stepper_pkg::MODE_HALF:  inc = `SD_STEP_UNIT >> 1;
            stepper_pkg::MODE_MICRO: inc = (ctrl[`SD_F_GRAN +: 2] == 2'h0) ? (`SD_STEP_UNIT >> 2)
                                         : (ctrl[`SD_F_GRAN +: 2] == 2'h1) ? (`SD_STEP_UNIT >> 3)
                                         : (`SD_STEP_UNIT >> 4); // RQ6
            default:                 inc = `SD_STEP_UNIT;
        endcase
    end

    // Position advances forward or back; it stays put at zero speed.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pos <= 6'h00;
        end else if (step_adv) begin
            pos <= ctrl[`SD_F_DIR] ? pos - inc[5:0] : pos + inc[5:0]; // RQ7 RQ11
        end
    end

    // ****************************************************************
    // Pattern and PWM
    // ****************************************************************
    // Level of one end (0 W, 1 X, 2 Y, 3 Z) as a fraction of 255.
    function automatic logic [7:0] end_level(input stepper_pkg::step_mode_e m,
                                             input logic [5:0] p, input logic [1:0] e,
                                             input logic [7:0] c, input logic [7:0] s);
        logic [3:0] on;
        logic [7:0] a, b;
        on = 4'h0;
        a  = p[4] ? s : c;
        b  = p[4] ? c : s;
        unique case (m) // RQ5
            stepper_pkg::MODE_WAVE: begin
                // W, Y, X, Z in turn.
                on = (p[5:4] == 2'h0) ? 4'b0001 : (p[5:4] == 2'h1) ? 4'b0100
                   : (p[5:4] == 2'h2) ? 4'b0010 : 4'b1000;
            end
            stepper_pkg::MODE_FULL: begin
                // WY, YX, XZ, ZW in turn.
                on = (p[5:4] == 2'h0) ? 4'b0101 : (p[5:4] == 2'h1) ? 4'b0110
                   : (p[5:4] == 2'h2) ? 4'b1010 : 4'b1001;
            end
            stepper_pkg::MODE_HALF: begin
                // Wave and full positions interleaved.
                on = (p[5:3] == 3'h0) ? 4'b0001 : (p[5:3] == 3'h1) ? 4'b0101
                   : (p[5:3] == 3'h2) ? 4'b0100 : (p[5:3] == 3'h3) ? 4'b0110
                   : (p[5:3] == 3'h4) ? 4'b0010 : (p[5:3] == 3'h5) ? 4'b1010
                   : (p[5:3] == 3'h6) ? 4'b1000 : 4'b1001;
            end
            default: begin
                // Phase A on W/X, phase B on Y/Z, sign by quadrant.
                on = {~p[5], p[5], p[5] ^ p[4], ~(p[5] ^ p[4])};
            end
        endcase
        // Off ends carry nothing; wave, full and half modes drive an on end fully.
        return !on[e] ? 8'h00 : (m != stepper_pkg::MODE_MICRO) ? 8'hff : e[1] ? b : a;
    endfunction : end_level

    logic [7:0] pwm_cnt;   // PWM ramp.
    logic [7:0] cos_lvl;   // Table level at this microstep.
    logic [7:0] sin_lvl;   // Table level at the mirrored microstep.
    logic       trip_prev; // Comparator level one cycle ago.
    assign cos_lvl = lut[pos[3:0]];
    assign sin_lvl = lut[~pos[3:0]];

    // Free-running PWM ramp.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwm_cnt <= 8'h00;
        end else begin
            pwm_cnt <= pwm_cnt + 8'h01;
        end
    end

    // A trip blanks the PWM until a period start with the comparator clear.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chopped   <= 1'b0;
            trip_prev <= 1'b0;
        end else begin
            trip_prev <= chop_trip_i;
            if (chop_trip_i) begin
                chopped <= 1'b1; // RQ13
            end else if (pwm_cnt == 8'hff) begin
                chopped <= 1'b0; // RQ13
            end
        end
    end

    // Four ends, each with its own duty and compare.
    for (genvar g = 0; g < 4; g++) begin : g_end
        logic [15:0] scaled; // Duty scaled by the end level.
        assign scaled = duty * end_level(mode, pos, 2'(g), cos_lvl, sin_lvl); // RQ11
        always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sw_o[g] <= 1'b0;
            end else begin
                sw_o[g] <= (pwm_cnt < scaled[15:8]) && !chop_trip_i && !chopped; // RQ12 RQ13
            end
        end
    end

    // Step, trip, start and stop events.
    assign events = {run_state == stepper_pkg::ST_RUN && duty < stop_thr,
                     run_state == stepper_pkg::ST_STOP && duty > run_thr,
                     chop_trip_i && !trip_prev, step_adv};

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_trip_blanks_pwm: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ13
        chop_trip_i |=> sw_o == 4'h0) else $error("switch on after trip");
    a_trip_restart: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ13
        (chopped && !chop_trip_i && pwm_cnt == 8'hff) |=> !chopped) else $error("no restart");
    a_duty_clamped: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ8
        (duty_min <= duty_max) |=> (duty <= $past(duty_max) && duty >= $past(duty_min)))
        else $error("duty outside limits");
    a_closed_duty_formula: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ2
        (ctrl[`SD_F_LOOP] && duty_raw <= {1'b0, duty_max} && duty_raw >= {1'b0, duty_min})
        |=> duty == $past(duty_raw[7:0])) else $error("duty formula");
    a_run_start: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ10
        (run_state == stepper_pkg::ST_STOP && duty > run_thr) |=> run_state == stepper_pkg::ST_RUN)
        else $error("no start");
    a_run_stop: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ10
        (run_state == stepper_pkg::ST_RUN && duty < stop_thr) |=> run_state == stepper_pkg::ST_STOP)
        else $error("no stop");
    a_zero_speed_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ17
        (speed_req == 8'h00) |=> pos == $past(pos)) else $error("moved at zero speed");
    a_dir_sequence: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ7
        (step_adv && ctrl[`SD_F_DIR]) |=> pos == 6'($past(pos) - $past(inc[5:0])))
        else $error("reverse step wrong");
    a_wave_single_end: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ5
        (mode == stepper_pkg::MODE_WAVE) |=> $countones(sw_o) <= 1) else $error("wave overlap");
    a_tick_spacing: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ16
        tick |=> !tick [*8]) else $error("tick too early");
endmodule : stepper_drive

// File: verif/motor_stage_model.sv
// Power stage model: four gate drives and a shunt current comparator.
// Assumes the gate drives change only on the system clock.
`timescale 1ns/1ps
module motor_stage_model (
    input  wire logic       mclk_i,   // System clock.
    input  wire logic [3:0] sw_i,     // Gate drives W, X, Y, Z.
    input  wire logic       over_i,   // Overcurrent set by the bench.
    input  wire logic       clr_i,    // Restarts the window.
    output logic            trip_o,   // Comparator output, high on trip.
    output logic      [3:0] seen_o,   // Switches seen on in the window.
    output logic      [8:0] on_cnt_o  // Cycles with any switch on.
);
    // The shunt passes the reference only while overcurrent is set.
    assign trip_o = over_i;
    // Accumulates which winding ends conducted, and for how long.
    always_ff @(posedge mclk_i) begin
        if (clr_i) begin
            seen_o   <= 4'h0;
            on_cnt_o <= 9'h000;
        end else begin
            seen_o   <= seen_o | sw_i;
            on_cnt_o <= on_cnt_o + 9'(|sw_i);
        end
    end
endmodule : motor_stage_model

// File: verif/stepper_drive_tb_top.sv
// Bench: register bus sequences on the stepper drive with expected values.
// Assumes the power stage model is compiled before it.
`timescale 1ns/1ps
module stepper_drive_tb_top;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic        over = 1'b0, clr = 1'b1, chop_trip_i, irq_o;
    logic [4:0]  addr_i = 5'h00, dac_level_o;
    logic [15:0] wdata_i = 16'h0000, rdata_o, v;
    logic [7:0]  pot_level_i = 8'h00;
    logic [3:0]  sw_o, seen;
    logic [8:0]  on_cnt;
    logic [5:0]  p0, p1;
    int          k, error_cnt = 0, samples_checked = 0;
    logic [20:0] rr [5] = '{21'h030080, 21'h051000, 21'h080008, 21'h090005, 21'h0d0000};
    logic [8:0]  hv [4] = '{9'h109, 9'h105, 9'h004, 9'h008};
    logic [7:0]  md [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h27, 8'h2b, 8'h31};
    logic [5:0]  inc [7] = '{6'h10, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h30};

    // System clock, 5 ns period.
    always #2.5 mclk_i = ~mclk_i;

    stepper_drive i_dut (.mclk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
                         .pot_level_i, .chop_trip_i, .dac_level_o, .sw_o, .irq_o);
    motor_stage_model i_stage (.mclk_i, .sw_i(sw_o), .over_i(over), .clr_i(clr),
                               .trip_o(chop_trip_i), .seen_o(seen), .on_cnt_o(on_cnt));

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One strobe cycle; read data are taken in the cycle after it.
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= w;
        rd_i    <= !w;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : bus
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc
    // Status once duty and run state have settled.
    task automatic sr;
        cyc(4);
        bus(1'b0, 5'h0b, 16'h0000);
    endtask : sr
    // Counts switch activity over one full PWM period.
    task automatic win;
        @(posedge mclk_i) clr <= 1'b1;
        @(posedge mclk_i) clr <= 1'b0;
        cyc(256);
    endtask : win
    // Waits for a step event, returns the position and clears the event.
    task automatic stp(output logic [5:0] p);
        k = 0;
        while (irq_o !== 1'b1 && k < 3000) begin
            cyc(1);
            k++;
        end
        // A step that never comes is a failure, not a silent pass.
        if (k >= 3000) error_cnt++;
        sr();
        p = v[7:2];
        bus(1'b1, 5'h0c, 16'h0001);
    endtask : stp
    task automatic print_verdict;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // Watchdog against a hung sequence.
    initial begin
        repeat (40000) @(posedge mclk_i);
        error_cnt++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        chk("reset outs", {6'h00, irq_o, sw_o, dac_level_o}, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, rr[i][20:16], 16'h0000);
            chk("reset reg", v, rr[i][15:0]);
        end
        bus(1'b1, 5'h0a, 16'h001f);
        cyc(2);
        chk("dac", 16'(dac_level_o), 16'h001f);
        bus(1'b1, 5'h00, 16'h0020);
        bus(1'b1, 5'h01, 16'h0040);
        bus(1'b1, 5'h04, 16'h0010);
        sr();
        chk("duty", 16'(v[15:8]), 16'h0030);
        bus(1'b1, 5'h07, 16'h0028);
        sr();
        chk("duty max", 16'(v[15:8]), 16'h0028);
        bus(1'b1, 5'h07, 16'h00ff);
        @(posedge mclk_i) pot_level_i <= 8'hff;
        bus(1'b1, 5'h00, 16'h0060);
        sr();
        chk("duty pot", 16'(v[15:8]), 16'h008f);
        bus(1'b1, 5'h00, 16'h0001);
        bus(1'b1, 5'h01, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 5'h02, 16'(hv[i][7:0]));
            sr();
            chk("running", 16'(v[0]), 16'(hv[i][8]));
        end
        bus(1'b1, 5'h02, 16'h0080);
        win();
        chk("on cycles", 16'(on_cnt), 16'h007f);
        chk("switches", 16'($countones(seen)), 16'h0002);
        @(posedge mclk_i) over <= 1'b1;
        cyc(2);
        chk("trip off", 16'(sw_o), 16'h0000);
        sr();
        chk("chopped", 16'(v[1]), 16'h0001);
        chk("irq masked", 16'(irq_o), 16'h0000);
        bus(1'b1, 5'h0d, 16'h0002);
        chk("irq raised", 16'(irq_o), 16'h0001);
        @(posedge mclk_i) over <= 1'b0;
        bus(1'b1, 5'h0c, 16'h0002);
        chk("irq cleared", 16'(irq_o), 16'h0000);
        cyc(600);
        win();
        chk("restart", 16'(on_cnt), 16'h007f);
        bus(1'b1, 5'h0d, 16'h0001);
        bus(1'b1, 5'h05, 16'h0002);
        bus(1'b1, 5'h01, 16'h0001);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, 5'h00, 16'(md[i]));
            bus(1'b1, 5'h0c, 16'h0001);
            stp(p0);
            stp(p1);
            chk("step", 16'(6'(p1 - p0)), 16'(inc[i]));
        end
        bus(1'b1, 5'h05, 16'h0008);
        stp(p0);
        stp(p1);
        chk("period", 16'(k > 1390 && k <= 1805), 16'h0001);
        bus(1'b1, 5'h01, 16'h0000);
        bus(1'b1, 5'h0c, 16'h0001);
        cyc(2000);
        bus(1'b0, 5'h0c, 16'h0000);
        chk("hold", v & 16'h0001, 16'h0000);
        print_verdict();
    end
endmodule : stepper_drive_tb_top
